/* qdsc_pkg.sv */
// qdsc_pkg: constants and carrier types for the quad dac serial command decoder.
// assumes nothing beyond a systemverilog compiler; shared by every design file except qdsc_sync.
package qdsc_pkg;

  // command word layout
  localparam int WORD_BITS = 24;
  localparam int RW_BIT = 23;
  localparam int ZERO_BIT = 22;
  localparam int REG_MSB = 21;
  localparam int REG_LSB = 19;
  localparam int CH_MSB = 18;
  localparam int CH_LSB = 16;
  localparam int DATA_MSB = 15;

  // register select codes
  localparam logic [2:0] REG_FUNC = 3'h0;
  localparam logic [2:0] REG_DATA = 3'h2;
  localparam logic [2:0] REG_COARSE = 3'h3;
  localparam logic [2:0] REG_FINE = 3'h4;
  localparam logic [2:0] REG_OFFSET = 3'h5;

  // channel codes; 0..3 are single channels
  localparam logic [2:0] CH_LAST = 3'h3;
  localparam logic [2:0] CH_ALL = 3'h4;

  // function codes
  localparam logic [2:0] FN_IDLE = 3'h0;
  localparam logic [2:0] FN_CTRL = 3'h1;
  localparam logic [2:0] FN_CLEAR = 3'h4;
  localparam logic [2:0] FN_LOAD = 3'h5;

  // control bit positions inside the function register
  localparam int CB_SDO_DIS = 0;
  localparam int CB_P0_VAL = 1;
  localparam int CB_P0_DIR = 2;
  localparam int CB_P1_VAL = 3;
  localparam int CB_P1_DIR = 4;
  localparam int CB_LGO = 5;
  localparam int CTRL_BITS = 6;

  // reset values
  localparam logic [5:0] CTRL_RST = 6'h00;
  localparam logic [15:0] CODE_RST = 16'h0000;
  localparam logic [1:0] COARSE_RST = 2'h0;
  localparam logic [5:0] FINE_RST = 6'h00;
  localparam logic [7:0] OFFSET_RST = 8'h00;
  localparam logic [23:0] RDW_RST = 24'h000000;

  // clear codes: zero volts in twos complement, negative full scale in offset binary
  localparam logic [15:0] CLR_TWOS = 16'h0000;
  localparam logic [15:0] CLR_OFFBIN = 16'h0000;

  // frame edge counting
  localparam int CNT_W = 5;
  localparam logic [4:0] CNT_FULL = 5'h18;
  localparam logic [4:0] CNT_OVER = 5'h19;

  // synchroniser width: frame, load, clear, coding, pin 0, pin 1
  localparam int SYNC_W = 6;

  typedef struct packed {
    logic rd;
    logic zero;
    logic [2:0] reg_sel;
    logic [2:0] chan;
    logic [15:0] data;
  } qdsc_cmd_t;

  typedef struct packed {
    logic [15:0] code;
    logic [1:0] coarse;
    logic [5:0] fine;
    logic [7:0] offset;
  } qdsc_chan_t;

endpackage

/* qdsc_sync.sv */
// qdsc_sync: two flip-flop level synchroniser, one per bit.
// assumes the inputs are levels that stay put for at least two clock periods.
`timescale 1ns/10ps
`default_nettype none
module qdsc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  always_comb begin
    meta_nxt = d;
    q_nxt = meta_r;
  end

  // resets to ones: every synchronised strobe idles high, so no false edge follows reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '1;
      q_r <= '1;
    end else begin
      meta_r <= meta_nxt;
      q_r <= q_nxt;
    end
  end

  assign q = q_r;

endmodule
`default_nettype wire

/* qdsc_link.sv */
// qdsc_link: shift-clock side of the serial port; shifts the word in, counts edges,
// shifts read-back data out.
// assumes the shift clock may stop outside frames and that rd_word is stable while
// frame select is low.
`timescale 1ns/10ps
`default_nettype none
module qdsc_link
  import qdsc_pkg::*;
(
  // link clock and reset
  input wire logic shift_clk,
  input wire logic rst_n,
  // serial pins
  input wire logic frame_sel_n,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  // core side; word and count stable between frames, rd_word stable while frame select is low
  input wire logic [23:0] rd_word,
  output qdsc_cmd_t word,
  output logic [4:0] edge_cnt
);

  logic fresh_r;
  logic fresh_clr;
  logic [23:0] shreg_r;
  logic [23:0] shreg_nxt;
  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  logic sout_r;
  logic sout_nxt;
  logic [4:0] idx;

  // marks that no edge of the current frame has come yet; set by frame select itself
  // because the shift clock may not run between frames
  assign fresh_clr = frame_sel_n | ~rst_n;

  always_ff @(negedge shift_clk or posedge fresh_clr) begin
    if (fresh_clr) begin
      fresh_r <= 1'b1;
    end else begin
      fresh_r <= 1'b0;
    end
  end

  always_comb begin
    shreg_nxt = shreg_r;
    cnt_nxt = cnt_r;
    if (!frame_sel_n) begin
      shreg_nxt = {shreg_r[22:0], serial_in_pin};
      if (fresh_r) begin
        cnt_nxt = 5'h01;
      end else if (cnt_r != CNT_OVER) begin
        cnt_nxt = cnt_r + 5'h01;
      end
    end
  end

  always_ff @(negedge shift_clk or negedge rst_n) begin
    if (!rst_n) begin
      shreg_r <= RDW_RST;
      cnt_r <= '0;
    end else begin
      shreg_r <= shreg_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // data leaves on the rising edge and is valid on the next falling edge
  assign idx = fresh_r ? 5'h00 : cnt_r;

  always_comb begin
    sout_nxt = sout_r;
    if (!frame_sel_n) begin
      if (idx < CNT_FULL) begin
        sout_nxt = rd_word[5'h17 - idx];
      end else begin
        sout_nxt = shreg_r[23];
      end
    end
  end

  always_ff @(posedge shift_clk or negedge rst_n) begin
    if (!rst_n) begin
      sout_r <= 1'b0;
    end else begin
      sout_r <= sout_nxt;
    end
  end

  assign serial_out_pin = sout_r;
  assign word = qdsc_cmd_t'(shreg_r);
  assign edge_cnt = cnt_r;

endmodule
`default_nettype wire

/* qdsc_decoder.sv */
// qdsc_decoder: top of the quad dac serial command decoder; decodes each framed
// word into channel data, gain, offset and function-register actions.
// assumes core_clk runs much faster than frames arrive (at least 4 core cycles
// between frame select rising and the next frame falling edge).
`timescale 1ns/10ps
`default_nettype none
module qdsc_decoder
  import qdsc_pkg::*;
(
  // core clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // serial link, clocked by the host
  input wire logic shift_clk,
  input wire logic frame_sel_n,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic serial_out_oe,
  // update and clear strobes, coding select
  input wire logic load_strobe_n,
  input wire logic clear_pin_n,
  input wire logic offset_binary,
  // general purpose pins
  input wire logic general_pin_zero_i,
  output logic general_pin_zero_o,
  output logic general_pin_zero_oe,
  input wire logic general_pin_one_i,
  output logic general_pin_one_o,
  output logic general_pin_one_oe,
  // channel state towards the analog path
  output qdsc_chan_t chan_out [4],
  output logic local_ground_adj_en
);

  // synchronised pin levels
  logic [SYNC_W-1:0] pin_sync;
  logic frame_s;
  logic load_s;
  logic clear_s;
  logic offbin_s;
  logic [1:0] gpin_s;

  // edge detection state
  logic frame_prev_r;
  logic frame_prev_nxt;
  logic load_prev_r;
  logic load_prev_nxt;
  logic clear_prev_r;
  logic clear_prev_nxt;
  logic frame_rise;
  logic load_fall;
  logic clear_fall;

  // link side
  qdsc_cmd_t lword;
  logic [4:0] lcnt;

  // register state
  logic [5:0] ctrl_r;
  logic [5:0] ctrl_nxt;
  logic [15:0] input_r [4];
  logic [15:0] input_nxt [4];
  qdsc_chan_t chan_r [4];
  qdsc_chan_t chan_nxt [4];
  logic [23:0] rdw_r;
  logic [23:0] rdw_nxt;

  // decode helpers
  logic frame_ok;
  logic [3:0] ch_hit;
  logic [15:0] clr_code;
  logic [5:0] ctrl_view;
  logic [15:0] rd_data;
  logic [1:0] rd_ch;

  qdsc_sync #(
    .W(SYNC_W)
  ) u_sync (
    .clk(core_clk),
    .rst_n(rst_n),
    .d({general_pin_one_i, general_pin_zero_i, offset_binary, clear_pin_n,
        load_strobe_n, frame_sel_n}),
    .q(pin_sync)
  );

  assign frame_s = pin_sync[0];
  assign load_s = pin_sync[1];
  assign clear_s = pin_sync[2];
  assign offbin_s = pin_sync[3];
  assign gpin_s = pin_sync[5:4];

  qdsc_link u_link (
    .shift_clk(shift_clk),
    .rst_n(rst_n),
    .frame_sel_n(frame_sel_n),
    .serial_in_pin(serial_in_pin),
    .serial_out_pin(serial_out_pin),
    .rd_word(rdw_r),
    .word(lword),
    .edge_cnt(lcnt)
  );

  // edges of the synchronised strobes
  always_comb begin
    frame_prev_nxt = frame_s;
    load_prev_nxt = load_s;
    clear_prev_nxt = clear_s;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_prev_r <= 1'b1;
      load_prev_r <= 1'b1;
      clear_prev_r <= 1'b1;
    end else begin
      frame_prev_r <= frame_prev_nxt;
      load_prev_r <= load_prev_nxt;
      clear_prev_r <= clear_prev_nxt;
    end
  end

  assign frame_rise = frame_s & ~frame_prev_r;
  assign load_fall = ~load_s & load_prev_r;
  assign clear_fall = ~clear_s & clear_prev_r;

  // word and count are only read here, while frame select is high and the link is still
  assign frame_ok = frame_rise && (lcnt == CNT_FULL) && !lword.zero;

  // channel hits; codes above all-channels match nothing
  always_comb begin
    ch_hit = 4'h0;
    if (lword.chan == CH_ALL) begin
      ch_hit = 4'hf;
    end else if (lword.chan <= CH_LAST) begin
      ch_hit[lword.chan[1:0]] = 1'b1;
    end
  end

  assign clr_code = offbin_s ? CLR_OFFBIN : CLR_TWOS;

  // an input pin reports its sampled level in place of the stored value
  always_comb begin
    ctrl_view = ctrl_r;
    if (!ctrl_r[CB_P0_DIR]) begin
      ctrl_view[CB_P0_VAL] = gpin_s[0];
    end
    if (!ctrl_r[CB_P1_DIR]) begin
      ctrl_view[CB_P1_VAL] = gpin_s[1];
    end
  end

  // read-back source; all-channels reads channel a
  assign rd_ch = (lword.chan == CH_ALL) ? 2'h0 : lword.chan[1:0];

  always_comb begin
    rd_data = 16'h0000;
    if (lword.chan <= CH_ALL) begin
      unique case (lword.reg_sel)
        REG_FUNC: begin
          if (lword.chan == FN_CTRL) begin
            rd_data = {10'h000, ctrl_view};
          end
        end
        REG_DATA: rd_data = input_r[rd_ch];
        REG_COARSE: rd_data = {14'h0000, chan_r[rd_ch].coarse};
        REG_FINE: rd_data = {10'h000, chan_r[rd_ch].fine};
        REG_OFFSET: rd_data = {8'h00, chan_r[rd_ch].offset};
        default: rd_data = 16'h0000;
      endcase
    end
  end

  // main register update
  always_comb begin
    ctrl_nxt = ctrl_r;
    rdw_nxt = rdw_r;
    for (int i = 0; i < 4; i++) begin
      input_nxt[i] = input_r[i];
      chan_nxt[i] = chan_r[i];
    end
    if (frame_ok) begin
      // read-back word is rebuilt each valid frame so stale data never leaks out
      rdw_nxt = RDW_RST;
      if (lword.rd) begin
        rdw_nxt = {lword.rd, lword.zero, lword.reg_sel, lword.chan, rd_data};
      end else begin
        unique case (lword.reg_sel)
          REG_FUNC: begin
            unique case (lword.chan)
              FN_IDLE: begin
                ctrl_nxt = ctrl_r;
              end
              FN_CTRL: begin
                ctrl_nxt[CB_LGO] = lword.data[CB_LGO];
                ctrl_nxt[CB_P1_DIR] = lword.data[CB_P1_DIR];
                ctrl_nxt[CB_P0_DIR] = lword.data[CB_P0_DIR];
                ctrl_nxt[CB_SDO_DIS] = lword.data[CB_SDO_DIS];
                // value bits only take a write when the pin is being made an output
                if (lword.data[CB_P1_DIR]) begin
                  ctrl_nxt[CB_P1_VAL] = lword.data[CB_P1_VAL];
                end
                if (lword.data[CB_P0_DIR]) begin
                  ctrl_nxt[CB_P0_VAL] = lword.data[CB_P0_VAL];
                end
              end
              FN_CLEAR: begin
                for (int i = 0; i < 4; i++) begin
                  input_nxt[i] = clr_code;
                  chan_nxt[i].code = clr_code;
                end
              end
              FN_LOAD: begin
                for (int i = 0; i < 4; i++) begin
                  chan_nxt[i].code = input_r[i];
                end
              end
              default: ctrl_nxt = ctrl_r;
            endcase
          end
          REG_DATA: begin
            for (int i = 0; i < 4; i++) begin
              if (ch_hit[i]) begin
                input_nxt[i] = lword.data;
                if (!load_s) begin
                  chan_nxt[i].code = lword.data;
                end
              end
            end
          end
          REG_COARSE: begin
            for (int i = 0; i < 4; i++) begin
              if (ch_hit[i]) begin
                chan_nxt[i].coarse = lword.data[1:0];
              end
            end
          end
          REG_FINE: begin
            for (int i = 0; i < 4; i++) begin
              if (ch_hit[i]) begin
                chan_nxt[i].fine = lword.data[5:0];
              end
            end
          end
          REG_OFFSET: begin
            for (int i = 0; i < 4; i++) begin
              if (ch_hit[i]) begin
                chan_nxt[i].offset = lword.data[7:0];
              end
            end
          end
          default: ctrl_nxt = ctrl_r;
        endcase
      end
    end
    // strobe pins act after the frame so they see the freshest input registers
    if (load_fall) begin
      for (int i = 0; i < 4; i++) begin
        chan_nxt[i].code = input_nxt[i];
      end
    end
    if (clear_fall) begin
      for (int i = 0; i < 4; i++) begin
        input_nxt[i] = clr_code;
        chan_nxt[i].code = clr_code;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= CTRL_RST;
      rdw_r <= RDW_RST;
      for (int i = 0; i < 4; i++) begin
        input_r[i] <= CODE_RST;
        chan_r[i] <= {CODE_RST, COARSE_RST, FINE_RST, OFFSET_RST};
      end
    end else begin
      ctrl_r <= ctrl_nxt;
      rdw_r <= rdw_nxt;
      for (int i = 0; i < 4; i++) begin
        input_r[i] <= input_nxt[i];
        chan_r[i] <= chan_nxt[i];
      end
    end
  end

  // outputs
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_chan
      assign chan_out[g] = chan_r[g];
    end
  endgenerate

  assign general_pin_zero_o = ctrl_r[CB_P0_VAL];
  assign general_pin_zero_oe = ctrl_r[CB_P0_DIR];
  assign general_pin_one_o = ctrl_r[CB_P1_VAL];
  assign general_pin_one_oe = ctrl_r[CB_P1_DIR];
  assign local_ground_adj_en = ctrl_r[CB_LGO];
  // output only drives inside a frame so a shared line stays free between frames
  assign serial_out_oe = ~frame_sel_n & ~ctrl_r[CB_SDO_DIS];

endmodule
`default_nettype wire

/* qdsc_decoder_props.sv */
// qdsc_decoder_props: timing checks on the decoder's outputs.
// assumes it is bound onto qdsc_decoder and frames are spaced as the contract asks.
`timescale 1ns/10ps
`default_nettype none
module qdsc_decoder_props
  import qdsc_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // strobes and frame
  input wire logic frame_sel_n,
  input wire logic load_strobe_n,
  input wire logic clear_pin_n,
  // watched outputs
  input wire logic serial_out_oe,
  input wire logic general_pin_zero_o,
  input wire logic general_pin_zero_oe,
  input wire logic general_pin_one_o,
  input wire logic general_pin_one_oe,
  input wire qdsc_chan_t chan_out [4],
  input wire logic local_ground_adj_en
);
  logic fr_r, ld_r, cl_r;
  logic [3:0] since_fr_r, since_fr_nxt, since_any_r, since_any_nxt;
  logic [63:0] codes, gains;
  logic [4:0] ctrl;
  assign codes = {chan_out[0].code, chan_out[1].code, chan_out[2].code, chan_out[3].code};
  assign gains = {chan_out[0][15:0], chan_out[1][15:0], chan_out[2][15:0], chan_out[3][15:0]};
  assign ctrl = {local_ground_adj_en, general_pin_one_oe, general_pin_one_o,
                 general_pin_zero_oe, general_pin_zero_o};
  // cycles since the last frame rise, and since any update cause
  always_comb begin
    since_fr_nxt = (since_fr_r == 4'hf) ? since_fr_r : since_fr_r + 4'h1;
    since_any_nxt = (since_any_r == 4'hf) ? since_any_r : since_any_r + 4'h1;
    if (frame_sel_n && !fr_r) begin
      since_fr_nxt = 4'h0;
      since_any_nxt = 4'h0;
    end
    if ((!load_strobe_n && ld_r) || (!clear_pin_n && cl_r))
      since_any_nxt = 4'h0;
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fr_r <= 1'b1;
      ld_r <= 1'b1;
      cl_r <= 1'b1;
      since_fr_r <= 4'hf;
      since_any_r <= 4'hf;
    end else begin
      fr_r <= frame_sel_n;
      ld_r <= load_strobe_n;
      cl_r <= clear_pin_n;
      since_fr_r <= since_fr_nxt;
      since_any_r <= since_any_nxt;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence frame_busy_s;
    (!frame_sel_n && load_strobe_n && clear_pin_n) [*6];
  endsequence
  sequence clear_edge_s;
    $fell(clear_pin_n);
  endsequence
  a_reset_defaults: assert property ($rose(rst_n) |-> codes == '0 && gains == '0 && ctrl == '0)
    else $error("state not at defaults after reset");
  a_oe_in_frame: assert property (serial_out_oe |-> !frame_sel_n)
    else $error("serial output driven outside a frame");
  a_oe_steady: assert property (!frame_sel_n && !$past(frame_sel_n) |-> $stable(serial_out_oe))
    else $error("serial output enable moved inside a frame");
  a_code_cause: assert property ($changed(codes) |-> since_any_r <= 4'h7)
    else $error("channel code changed without frame, load or clear");
  a_gain_cause: assert property ($changed(gains) |-> since_fr_r <= 4'h7)
    else $error("gain or offset changed without a frame");
  a_ctrl_cause: assert property ($changed(ctrl) |-> since_fr_r <= 4'h7)
    else $error("control bits changed without a frame");
  a_quiet_frame: assert property (frame_busy_s |=> $stable(codes) && $stable(gains))
    else $error("state changed while a frame was shifting");
  a_clear_zero: assert property (clear_edge_s |-> ##[2:6] codes == {4{CLR_TWOS}})
    else $error("clear did not reach the clear code");
endmodule
bind qdsc_decoder qdsc_decoder_props u_props (
  .core_clk, .rst_n, .frame_sel_n, .load_strobe_n, .clear_pin_n, .serial_out_oe,
  .general_pin_zero_o, .general_pin_zero_oe, .general_pin_one_o, .general_pin_one_oe,
  .chan_out, .local_ground_adj_en
);
`default_nettype wire

/* qdsc_host.sv */
// qdsc_host: behavioural host serial port sending framed 24-bit words.
// assumes the bench calls xfer; the model itself leaves the gap between frames.
`timescale 1ns/10ps
`default_nettype none
module qdsc_host (
  // serial pins towards the decoder
  output logic shift_clk,
  output logic frame_sel_n,
  output logic serial_in_pin,
  input wire logic serial_out_pin,
  input wire logic serial_out_oe
);
  initial begin
    shift_clk = 1'b0;
    frame_sel_n = 1'b1;
    serial_in_pin = 1'b0;
  end
  // clock rests low between frames so each bit is a rise then a fall
  task automatic xfer(input logic [23:0] w, input int n, output logic [23:0] rb,
                      output logic oe);
    rb = 24'h000000;
    oe = 1'b0;
    frame_sel_n = 1'b0;
    // data moves on the rising edge so it is settled well before the sampling fall
    for (int i = 0; i < n; i++) begin
      #6 shift_clk = 1'b1;
      serial_in_pin = (i < 24) ? w[23 - i] : ~serial_in_pin;
      #6 shift_clk = 1'b0;
      rb = {rb[22:0], serial_out_pin};
      oe = oe | serial_out_oe;
    end
    #6 frame_sel_n = 1'b1;
    serial_in_pin = ~serial_in_pin;
    #240;
  endtask
endmodule
`default_nettype wire

/* test_quad_dac_serial_command_decoder.sv */
// test_quad_dac_serial_command_decoder: self-checking bench for qdsc_decoder.
// assumes qdsc_host plays the serial host and the checker is bound to the decoder.
`timescale 1ns/10ps
`default_nettype none
module test_quad_dac_serial_command_decoder
  import qdsc_pkg::*;
;
  logic core_clk, rst_n, shift_clk, frame_sel_n, serial_in_pin, serial_out_pin, serial_out_oe;
  logic load_strobe_n, clear_pin_n, offset_binary, p0_i, p1_i, p0_o, p0_oe, p1_o, p1_oe, lge;
  qdsc_chan_t chan_out [4];
  logic [15:0] e_in [4], e_code [4];
  logic [1:0] e_co [4];
  logic [5:0] e_fi [4];
  logic [7:0] e_of [4];
  logic [5:0] e_ctl;
  logic [23:0] rb, e_rb, bad [9];
  logic [2:0] r, c, regs [5], fns [4];
  logic oe;
  logic [31:0] seed;
  int fails = 0;
  int total_checks = 0;
  int cyc = 0;
  qdsc_decoder dut (
    .core_clk, .rst_n, .shift_clk, .frame_sel_n, .serial_in_pin, .serial_out_pin,
    .serial_out_oe, .load_strobe_n, .clear_pin_n, .offset_binary,
    .general_pin_zero_i(p0_i), .general_pin_zero_o(p0_o), .general_pin_zero_oe(p0_oe),
    .general_pin_one_i(p1_i), .general_pin_one_o(p1_o), .general_pin_one_oe(p1_oe),
    .chan_out, .local_ground_adj_en(lge)
  );
  qdsc_host host (.shift_clk, .frame_sel_n, .serial_in_pin, .serial_out_pin, .serial_out_oe);
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
  endfunction
  function automatic logic [15:0] rdval(input logic [2:0] rs, input logic [2:0] cs);
    int k;
    k = (cs == CH_ALL) ? 0 : int'(cs);
    case (rs)
      REG_DATA: return e_in[k];
      REG_COARSE: return {14'h0000, e_co[k]};
      REG_FINE: return {10'h000, e_fi[k]};
      REG_OFFSET: return {8'h00, e_of[k]};
      REG_FUNC: return (cs != FN_CTRL) ? 16'h0000 : {10'h000, e_ctl[5:4],
        e_ctl[4] ? e_ctl[3] : p1_i, e_ctl[2], e_ctl[2] ? e_ctl[1] : p0_i, e_ctl[0]};
      default: return 16'h0000;
    endcase
  endfunction
  // updates the expected state for one accepted word
  function automatic void model(input logic [23:0] w);
    logic [15:0] d;
    d = w[15:0];
    if (w[22])
      return;
    if (w[23]) begin
      e_rb = {w[23:16], rdval(w[21:19], w[18:16])};
      return;
    end
    for (int k = 0; k < 4; k++) begin
      if (w[21:19] == REG_FUNC && w[18:16] == FN_CLEAR) begin
        e_in[k] = offset_binary ? CLR_OFFBIN : CLR_TWOS;
        e_code[k] = e_in[k];
      end
      if (w[21:19] == REG_FUNC && w[18:16] == FN_LOAD)
        e_code[k] = e_in[k];
      if (w[21:19] != REG_FUNC && (w[18:16] == CH_ALL || w[18:16] == 3'(k))) begin
        case (w[21:19])
          REG_DATA: begin
            e_in[k] = d;
            if (!load_strobe_n)
              e_code[k] = d;
          end
          REG_COARSE: e_co[k] = d[1:0];
          REG_FINE: e_fi[k] = d[5:0];
          REG_OFFSET: e_of[k] = d[7:0];
          default: ;
        endcase
      end
    end
    if (w[21:16] == {REG_FUNC, FN_CTRL}) begin
      e_ctl = {d[5:4], d[4] ? d[3] : e_ctl[3], d[2], d[2] ? d[1] : e_ctl[1], d[0]};
    end
  endfunction
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic check_state();
    for (int k = 0; k < 4; k++) begin
      chk({chan_out[k].code, chan_out[k].coarse, chan_out[k].fine}, {e_code[k], e_co[k], e_fi[k]});
      chk({16'h0000, chan_out[k].offset}, {16'h0000, e_of[k]});
    end
    chk({19'h00000, lge, p1_oe, p1_o, p0_oe, p0_o}, {19'h00000, e_ctl[5:1]});
  endtask
  task automatic frame(input logic [23:0] w, input int n);
    @(negedge core_clk);
    host.xfer(w, n, rb, oe);
    if (n == 24)
      model(w);
    repeat (8) @(posedge core_clk);
  endtask
  task automatic set_load_strobe_n(input logic v);
    for (int k = 0; k < 4; k++)
      if (load_strobe_n && !v)
        e_code[k] = e_in[k];
    load_strobe_n <= v;
    repeat (6) @(posedge core_clk);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      fails++;
      give_verdict();
    end
  end
  initial begin
    seed = 32'h5baeb2c4;
    {rst_n, offset_binary, p0_i, p1_i} = 4'h0;
    {load_strobe_n, clear_pin_n} = 2'h3;
    regs = '{REG_FUNC, REG_DATA, REG_COARSE, REG_FINE, REG_OFFSET};
    fns = '{FN_IDLE, FN_CTRL, FN_CLEAR, FN_LOAD};
    bad = '{24'h4a1234, 24'h08ffff, 24'h30ffff, 24'h38ffff, 24'h15ffff,
            24'h02ffff, 24'h03ffff, 24'h06ffff, 24'h07ffff};
    e_ctl = CTRL_RST;
    e_rb = RDW_RST;
    for (int k = 0; k < 4; k++)
      {e_in[k], e_code[k], e_co[k], e_fi[k], e_of[k]} = '0;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    check_state();
    $display("reset defaults test done");
    for (int i = 0; i < 60; i++) begin
      seed = lfsr(seed);
      offset_binary <= seed[20];
      set_load_strobe_n(seed[21]);
      r = regs[int'(seed[26:24]) % 5];
      c = (r == REG_FUNC) ? fns[seed[28:27]] : 3'(int'(seed[31:29]) % 5);
      frame({2'b00, r, c, seed[15:0]}, 24);
      check_state();
    end
    set_load_strobe_n(1'b0);
    check_state();
    $display("random write test done");
    frame(24'h01003e, 24);
    frame(24'h010008, 24);
    check_state();
    clear_pin_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    clear_pin_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    model(24'h040000);
    check_state();
    $display("function and clear test done");
    for (int i = 0; i < 24; i++) begin
      seed = lfsr(seed);
      {p0_i, p1_i} <= seed[1:0];
      if (i % 8 == 5)
        frame({8'h01, 10'h000, seed[7:3], i > 12}, 24);
      r = regs[i % 5];
      c = (r == REG_FUNC) ? (seed[3] ? FN_CTRL : FN_IDLE) : 3'(int'(seed[6:4]) % 5);
      frame({2'b10, r, c, seed[31:16]}, 24);
      frame(24'h000000, 24);
      if (!e_ctl[0])
        chk(rb, e_rb);
      chk({23'h000000, oe}, {23'h000000, ~e_ctl[0]});
    end
    $display("read back test done");
    foreach (bad[i]) begin
      frame(bad[i], 24);
      check_state();
    end
    frame(24'h10ffff, 23);
    check_state();
    frame(24'h10ffff, 25);
    check_state();
    $display("refused frame test done");
    give_verdict();
  end
endmodule
`default_nettype wire
